/* hdl/nsc_counter.sv */
`timescale 1ns/1ns
module nsc_counter #(
  parameter int W = 8,
  parameter int TOP = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic enable_i,          // Collection on
  input wire logic [15:0] inc_i,      // Amount of a network event
  input wire logic inc_vld_i,         // Event strobe
  input wire logic clr_i,             // Host read of this counter
  input wire logic add_i,             // Host write of this counter
  input wire logic [15:0] add_val_i,  // Value to add
  output logic [15:0] value_o,        // Zero-extended count
  output logic near_full_o            // Top bits all set
);
  import nsc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [W-1:0] cnt;      // Counter value
    logic [15:0] pend;      // Events held while collection is off
    logic pend_vld;         // Pending events present
  } nsc_cnt_st_t;

  nsc_cnt_st_t st_reg;
  nsc_cnt_st_t st_next;

  // Next state
  always_comb begin
    st_next = st_reg;
    // A host read empties the counter in either collection state
    if (clr_i) begin
      st_next.cnt = '0;
    end
    if (enable_i) begin
      // Apply held events, then live ones, so none is lost to a clear
      if (st_reg.pend_vld) begin
        st_next.cnt = st_next.cnt + st_reg.pend[W-1:0];
        st_next.pend = 16'h0000;
        st_next.pend_vld = 1'b0;
      end
      if (inc_vld_i) begin
        st_next.cnt = st_next.cnt + inc_i[W-1:0];
      end
    end else begin
      // Latch events while off so none is lost
      if (inc_vld_i) begin
        st_next.pend = st_reg.pend + inc_i;
        st_next.pend_vld = 1'b1;
      end
      // Debug write adds to the count; a read in the same cycle wins
      if (add_i && !clr_i) begin
        st_next.cnt = st_reg.cnt + add_val_i[W-1:0];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero fill to sixteen bits
  assign value_o = 16'(st_reg.cnt);
  assign near_full_o = &st_reg.cnt[W-1 -: TOP];

endmodule

/* hdl/nsc_pkg.sv */
package nsc_pkg;

  // ==========================================================
  // Port offsets of the statistics window
  // ==========================================================
  localparam logic [3:0] NSC_OFS_CARRIER_LOSS = 4'h0;
  localparam logic [3:0] NSC_OFS_MISS_HBEAT = 4'h1;
  localparam logic [3:0] NSC_OFS_MULTI_COLL = 4'h2;
  localparam logic [3:0] NSC_OFS_SINGLE_COLL = 4'h3;
  localparam logic [3:0] NSC_OFS_LATE_COLL = 4'h4;
  localparam logic [3:0] NSC_OFS_RX_OVERRUN = 4'h5;
  localparam logic [3:0] NSC_OFS_TX_FRAME = 4'h6;
  localparam logic [3:0] NSC_OFS_RX_FRAME = 4'h7;
  localparam logic [3:0] NSC_OFS_TX_DEFER = 4'h8;
  localparam logic [3:0] NSC_OFS_RX_BYTE = 4'hA;
  localparam logic [3:0] NSC_OFS_TX_BYTE = 4'hC;

  // ==========================================================
  // Counter indices and widths
  // ==========================================================
  localparam int NSC_NUM_CNT = 11;
  localparam int NSC_IDX_RX_BYTE = 9;
  localparam int NSC_IDX_TX_BYTE = 10;
  localparam int NSC_W4 = 4;
  localparam int NSC_W6 = 6;
  localparam int NSC_W8 = 8;
  localparam int NSC_W16 = 16;
  // Number of top bits that must all be set on wide counters
  localparam int NSC_WIDE_TOP_BITS = 3;
  localparam logic [15:0] NSC_CNT_RESET = 16'h0000;

  // Event strobes and frame byte counts from the MAC
  typedef struct packed {
    logic [15:0] tx_bytes;  // Byte count of a good transmit frame
    logic [15:0] rx_bytes;  // Byte count of a good receive frame
    logic tx_defer;         // Transmit deferred
    logic rx_good;          // Good receive frame done
    logic tx_good;          // Good transmit frame done
    logic rx_overrun;       // Receive frame reported as overrun
    logic late_coll;        // Late collision on transmit
    logic single_coll;      // Frame sent after one collision
    logic multi_coll;       // Frame sent after several collisions
    logic no_hbeat;         // Frame sent without collision_detect_pulse
    logic carrier_loss;     // Carrier sense lost in transmission
  } nsc_evt_t;

  // Host access to the statistics port window
  typedef struct packed {
    logic rd;               // One-cycle read strobe
    logic wr;               // One-cycle write strobe
    logic word;             // 1 = word access, 0 = byte access
    logic [3:0] addr;       // Port offset
    logic [15:0] wdata;     // Write data
  } nsc_host_t;

endpackage

/* hdl/nsc_read_tracker.sv */
`timescale 1ns/1ns
module nsc_read_tracker #(
  parameter int N = 11
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] rd_hit_i,  // Counter read this cycle
  input wire logic any_near_i,        // A counter is near full
  output logic update_o               // Update status flag
);
  import nsc_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [N-1:0] seen;     // Counters read since flag went up
    logic flag;             // Update status
  } nsc_trk_st_t;

  nsc_trk_st_t st_reg;
  nsc_trk_st_t st_next;

  // Flag sets on near full, clears when all counters read
  always_comb begin
    st_next = st_reg;
    st_next.seen = st_reg.seen | rd_hit_i;
    // Clear one cycle after the last read, once its counter has emptied,
    // so the near-full counter read last cannot hold the flag up
    if (st_reg.flag && (&st_reg.seen) && !any_near_i) begin
      st_next.flag = 1'b0;
      st_next.seen = '0;
    end
    // Set wins over clear
    if (any_near_i) begin
      st_next.flag = 1'b1;
    end
    if (!st_reg.flag && !any_near_i) begin
      st_next.seen = '0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign update_o = st_reg.flag;

endmodule

/* hdl/nsc_stats.sv */
`timescale 1ns/1ns
module nsc_stats (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stats_enable_i,          // Collection enable command
  input wire logic stats_disable_i,         // Collection disable command
  input wire logic heartbeat_count_enable_i, // Media status bit 3
  input wire nsc_pkg::nsc_evt_t evt_i,      // Network event strobes
  input wire nsc_pkg::nsc_host_t host_i,    // Host port access
  output logic [15:0] rdata_o,              // Read data
  output logic rvalid_o,                    // Read data valid pulse
  output logic collect_on_o,                // Collection state
  output logic update_stats_o               // Update status flag
);
  import nsc_pkg::*;

  // ==========================================================
  // Top state
  // ==========================================================
  typedef struct packed {
    logic on;               // Collection enabled
    logic [15:0] rdata;     // Read data register
    logic rvalid;           // Read answer pulse
  } nsc_top_st_t;

  nsc_top_st_t st_reg;
  nsc_top_st_t st_next;

  logic [NSC_NUM_CNT-1:0] hit;      // Address decode per counter
  logic [NSC_NUM_CNT-1:0] inc_vld;  // Event per counter
  logic [NSC_NUM_CNT-1:0] near;     // Near-full per counter
  logic [15:0] inc_amt [NSC_NUM_CNT];
  logic [15:0] val [NSC_NUM_CNT];
  logic update;

  // Offset table in counter index order
  localparam logic [3:0] OFS [NSC_NUM_CNT] = '{
    NSC_OFS_CARRIER_LOSS, NSC_OFS_MISS_HBEAT, NSC_OFS_MULTI_COLL,
    NSC_OFS_SINGLE_COLL, NSC_OFS_LATE_COLL, NSC_OFS_RX_OVERRUN,
    NSC_OFS_TX_FRAME, NSC_OFS_RX_FRAME, NSC_OFS_TX_DEFER,
    NSC_OFS_RX_BYTE, NSC_OFS_TX_BYTE};
  localparam int WID [NSC_NUM_CNT] = '{
    NSC_W4, NSC_W4, NSC_W6, NSC_W6, NSC_W8, NSC_W8, NSC_W8, NSC_W8,
    NSC_W8, NSC_W16, NSC_W16};

  // ==========================================================
  // Event routing
  // ==========================================================
  always_comb begin
    inc_vld[0] = evt_i.carrier_loss;
    inc_vld[1] = evt_i.no_hbeat && heartbeat_count_enable_i;
    inc_vld[2] = evt_i.multi_coll;
    inc_vld[3] = evt_i.single_coll;
    inc_vld[4] = evt_i.late_coll;
    inc_vld[5] = evt_i.rx_overrun;
    inc_vld[6] = evt_i.tx_good;
    inc_vld[7] = evt_i.rx_good;
    inc_vld[8] = evt_i.tx_defer;
    inc_vld[9] = evt_i.rx_good && (evt_i.rx_bytes != 16'h0000);
    inc_vld[10] = evt_i.tx_good && (evt_i.tx_bytes != 16'h0000);
    for (int i = 0; i < 9; i++) begin
      inc_amt[i] = 16'h0001;
    end
    inc_amt[9] = evt_i.rx_bytes;
    inc_amt[10] = evt_i.tx_bytes;
  end

  // ==========================================================
  // Counters
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < NSC_NUM_CNT; g++) begin : g_cnt
      // Access width must match counter class
      assign hit[g] = (host_i.addr == OFS[g]) &&
                      (host_i.word == (WID[g] == NSC_W16));
      nsc_counter #(
        .W(WID[g]),
        .TOP((WID[g] == NSC_W16) ? NSC_WIDE_TOP_BITS : 1)
      ) u_cnt (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(st_reg.on),
        .inc_i(inc_amt[g]),
        .inc_vld_i(inc_vld[g]),
        .clr_i(hit[g] && host_i.rd),
        .add_i(hit[g] && host_i.wr && !st_reg.on),
        .add_val_i(host_i.wdata),
        .value_o(val[g]),
        .near_full_o(near[g])
      );
    end
  endgenerate

  // Update flag tracking
  nsc_read_tracker #(
    .N(NSC_NUM_CNT)
  ) u_trk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .rd_hit_i(hit & {NSC_NUM_CNT{host_i.rd}}),
    .any_near_i(|near),
    .update_o(update)
  );

  // ==========================================================
  // Host side: enable state and read data
  // ==========================================================
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = host_i.rd;
    if (stats_disable_i) begin
      st_next.on = 1'b0;
    end else if (stats_enable_i) begin
      st_next.on = 1'b1;
    end
    if (host_i.rd) begin
      // Unmapped offsets read zero
      st_next.rdata = 16'h0000;
      for (int i = 0; i < NSC_NUM_CNT; i++) begin
        if (hit[i]) begin
          st_next.rdata = val[i];
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Update flag output register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      update_stats_o <= 1'b0;
    end else begin
      update_stats_o <= update;
    end
  end

  assign rdata_o = st_reg.rdata;
  assign rvalid_o = st_reg.rvalid;
  assign collect_on_o = st_reg.on;

endmodule

/* testbench/nsc_stats_monitor.sv */
`timescale 1ns/1ns
module nsc_stats_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stats_enable_i,
  input wire logic stats_disable_i,
  input wire logic heartbeat_count_enable_i,
  input wire nsc_pkg::nsc_evt_t evt_i,
  input wire nsc_pkg::nsc_host_t host_i,
  input wire logic [15:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic collect_on_o,
  input wire logic update_stats_o
);
  import nsc_pkg::*;
  // ==========================================================
  // Host read path, collection state and update flag
  // ==========================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_answer: assert property (host_i.rd |=> rvalid_o)
    else $error("read strobe got no answer");
  a_valid_pulse: assert property (!host_i.rd |=> !rvalid_o)
    else $error("read valid without a read");
  a_rdata_hold: assert property (!host_i.rd |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_four_bit_ext: assert property (host_i.rd && host_i.addr < 4'h2
    |=> rdata_o[15:4] == 12'h000)
    else $error("four-bit counter not zero filled");
  a_six_bit_ext: assert property (host_i.rd && host_i.addr[3:1] == 3'h1
    |=> rdata_o[15:6] == 10'h000)
    else $error("six-bit counter not zero filled");
  a_wrong_size: assert property (host_i.rd && (host_i.word !=
    (host_i.addr == NSC_OFS_RX_BYTE || host_i.addr == NSC_OFS_TX_BYTE))
    |=> rdata_o == 16'h0000)
    else $error("wrong size read returned data");
  a_collect_on: assert property (stats_enable_i && !stats_disable_i
    |=> collect_on_o)
    else $error("enable command ignored");
  a_collect_off: assert property (stats_disable_i |=> !collect_on_o)
    else $error("disable command ignored");
  a_update_fall: assert property ($fell(update_stats_o)
    |-> $past(host_i.rd) || $past(host_i.rd, 2) || $past(host_i.rd, 3))
    else $error("update flag dropped without reads");
endmodule
bind nsc_stats nsc_stats_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .stats_enable_i(stats_enable_i), .stats_disable_i(stats_disable_i),
  .heartbeat_count_enable_i(heartbeat_count_enable_i), .evt_i(evt_i),
  .host_i(host_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .collect_on_o(collect_on_o), .update_stats_o(update_stats_o));

/* testbench/nsc_stats_tb.sv */
`timescale 1ns/1ns
module nsc_stats_tb;
  import nsc_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic clk_i, rst_n_i, stats_enable_i, stats_disable_i;
  logic heartbeat_count_enable_i;
  nsc_evt_t evt_i;
  nsc_host_t host_i;
  logic [15:0] rdata_o;
  logic rvalid_o, collect_on_o, update_stats_o;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  // Counter offsets, byte ones first
  logic [3:0] ofs [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'h8, 4'hA, 4'hC};
  nsc_stats uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .stats_enable_i(stats_enable_i), .stats_disable_i(stats_disable_i),
    .heartbeat_count_enable_i(heartbeat_count_enable_i), .evt_i(evt_i),
    .host_i(host_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .collect_on_o(collect_on_o), .update_stats_o(update_stats_o));
  // 25 MHz clock
  initial begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("[FAIL] timeout expected done seen hang");
      end_of_test();
    end
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Pulse a collection command for one cycle
  task automatic cmd(logic en, logic dis);
    @(posedge clk_i);
    #1;
    stats_enable_i = en;
    stats_disable_i = dis;
    @(posedge clk_i);
    #1;
    stats_enable_i = 0;
    stats_disable_i = 0;
  endtask
  // Pulse a set of network events for one cycle
  task automatic evt(nsc_evt_t e);
    @(posedge clk_i);
    #1;
    evt_i = e;
    @(posedge clk_i);
    #1;
    evt_i = '0;
  endtask
  // One host access; read data is settled on return
  task automatic acc(logic r, logic w, logic [3:0] a, logic [15:0] v);
    @(posedge clk_i);
    #1;
    host_i = '{rd: r, wr: !r, word: w, addr: a, wdata: v};
    @(posedge clk_i);
    #1;
    host_i = '0;
  endtask
  task automatic rd(logic [3:0] a, logic w, logic [15:0] exp);
    acc(1, w, a, 16'h0000);
    check("rvalid", 16'h0001, {15'h0000, rvalid_o});
    check($sformatf("count at %h", a), exp, rdata_o);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 11; i++) begin
      rd(ofs[i], i > 8, 16'h0000);
    end
  endtask
  task automatic flag(logic exp);
    repeat (3) @(posedge clk_i);
    #1;
    check("update flag", {15'h0000, exp}, {15'h0000, update_stats_o});
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_map();
    heartbeat_count_enable_i = 1;
    cmd(1, 0);
    evt('{tx_bytes: 16'h0005, rx_bytes: 16'h0007, default: 1'b1});
    cmd(0, 1);
    for (int i = 0; i < 9; i++) begin
      rd(ofs[i], 0, 16'h0001);
    end
    rd(4'hA, 1, 16'h0007);
    rd(4'hC, 1, 16'h0005);
    rd_all();
    $display("t_map done");
  endtask
  task automatic t_gate();
    heartbeat_count_enable_i = 0;
    cmd(1, 0);
    evt('{no_hbeat: 1'b1, default: '0});
    cmd(0, 1);
    rd(4'h1, 0, 16'h0000);
    evt('{tx_good: 1'b1, default: '0});
    rd(4'h6, 0, 16'h0000);
    cmd(1, 0);
    cmd(0, 1);
    rd(4'h6, 0, 16'h0001);
    $display("t_gate done");
  endtask
  task automatic t_write();
    acc(0, 0, 4'h6, 16'h0003);
    acc(0, 0, 4'h6, 16'h0004);
    rd(4'h6, 0, 16'h0007);
    acc(0, 0, 4'h0, 16'h00ff);
    rd(4'h0, 0, 16'h000f);
    acc(0, 0, 4'h2, 16'h00ff);
    rd(4'h2, 0, 16'h003f);
    acc(0, 1, 4'hA, 16'h1234);
    rd(4'hA, 0, 16'h0000);
    rd(4'hA, 1, 16'h1234);
    cmd(1, 0);
    acc(0, 0, 4'h6, 16'h0009);
    cmd(0, 1);
    rd(4'h6, 0, 16'h0000);
    $display("t_write done");
  endtask
  task automatic t_update();
    rd_all();
    flag(0);
    acc(0, 0, 4'h0, 16'h0008);
    flag(1);
    rd(4'h0, 0, 16'h0008);
    flag(1);
    rd_all();
    flag(0);
    acc(0, 1, 4'hA, 16'hc000);
    flag(0);
    acc(0, 1, 4'hA, 16'h2000);
    flag(1);
    rd(4'hA, 1, 16'he000);
    rd_all();
    flag(0);
    cmd(1, 0);
    cmd(0, 1);
    rd_all();
    flag(0);
    $display("t_update done");
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst_n_i = 0;
    stats_enable_i = 0;
    stats_disable_i = 0;
    heartbeat_count_enable_i = 0;
    evt_i = '0;
    host_i = '0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_n_i = 1;
    check("collect after reset", 16'h0000, {15'h0000, collect_on_o});
    t_map();
    t_gate();
    t_write();
    t_update();
    end_of_test();
  end
endmodule
